// ==== core/udcl_pkg.sv ====
`default_nettype none
// =====================================================================
// Shared constants and types of the up/down counter
// =====================================================================
package udcl_pkg;

    // =================================================================
    // Timing
    // =================================================================
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1000;
    localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1000) * TICK_PERIOD_MS;

    // =================================================================
    // Count
    // =================================================================
    localparam int unsigned CNT_W     = 4;
    localparam logic [3:0]  CNT_RESET = 4'h0;
    localparam logic [3:0]  CNT_STEP  = 4'h1;

    // =================================================================
    // Register port
    // =================================================================
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 32;
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam logic [3:0]  REG_DIV    = 4'h8;
    localparam int unsigned CTRL_DOT   = 0;
    localparam int unsigned CTRL_INV   = 1;
    localparam logic [1:0]  CTRL_RESET = 2'h0;
    localparam int unsigned STAT_CNT   = 0;
    localparam int unsigned STAT_EN    = 4;
    localparam int unsigned STAT_UP    = 5;
    localparam int unsigned STAT_CLR   = 6;
    localparam int unsigned STAT_LOAD  = 7;
    localparam int unsigned STAT_DOT   = 8;

    // =================================================================
    // Types
    // =================================================================
    typedef struct packed {
        logic       load;
        logic       up;
        logic       clr;
        logic       en;
        logic [3:0] data;
    } udcl_ctrl_t;

    // Bit 0 is segment a, bit 6 is segment g
    typedef struct packed {
        logic       dp;
        logic [6:0] seg;
    } udcl_seg_t;

    typedef enum logic [4:0] {
        OP_HOLD  = 5'h01,
        OP_CLEAR = 5'h02,
        OP_LOAD  = 5'h04,
        OP_UP    = 5'h08,
        OP_DOWN  = 5'h10
    } udcl_op_t;

    // Hex font, active high, gfedcba
    localparam logic [6:0] SEG_FONT [16] = '{
        7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
        7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71
    };
    localparam udcl_seg_t SEG_RESET = '{dp: 1'b0, seg: 7'h3f};

endpackage : udcl_pkg
`default_nettype wire

// ==== core/udcl_seg_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Registered seven-segment decoder
// =====================================================================
module udcl_seg_decode (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rstn,
    // Value to show
    input  wire logic [3:0]         value,
    input  wire logic               dot,
    input  wire logic               invert,
    // Display drive
    output udcl_pkg::udcl_seg_t     seg_r
);

    udcl_pkg::udcl_seg_t seg_nxt;

    always_comb begin
        seg_nxt.seg = udcl_pkg::SEG_FONT[value] ^ {7{invert}};
        seg_nxt.dp  = dot ^ invert;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            seg_r <= udcl_pkg::SEG_RESET;
        end else begin
            seg_r <= seg_nxt;
        end
    end

endmodule : udcl_seg_decode
`default_nettype wire

// ==== core/udcl_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Up/down counter, one step per second, with load and display
// =====================================================================
// Contract
// R1: A divider counts clock cycles up to a terminal constant and gives a one-per-second tick.
// R2: The count changes by counting at most once per tick.
// R3: The count is four bits wide and runs from 0 to F.
// R4: With enable low the count holds.
// R5: Enabled, each tick counts up when direction is high and down when it is low.
// R6: A raised clear forces the count to zero.
// R7: A raised load puts the data inputs into the count at the next clock edge.
// R8: The loaded value comes from data bits zero to three.
// R9: The switches preset a value by driving data, raising load, then lowering it.
// R10: The count is decoded onto segments a to g plus a dot.
// R11: Reset sets the count and the divider to zero.
// R12: Clear beats load, load beats counting, and the count wraps modulo sixteen.
module udcl_counter #(
    parameter int unsigned TICK_CYCLES = udcl_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    // Switch inputs
    input  wire udcl_pkg::udcl_ctrl_t    ctrl_in,
    // Register port
    input  wire logic [3:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    // Display and count
    output udcl_pkg::udcl_seg_t          seg_out,
    output logic [3:0]                   count_out
);

    localparam int unsigned DIV_W    = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_TERM = DIV_W'(TICK_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);

    // =================================================================
    // Divider
    // =================================================================
    logic [DIV_W-1:0] div_cnt_r;
    logic [DIV_W-1:0] div_cnt_nxt;
    logic             tick_r;
    logic             tick_nxt;

    always_comb begin
        tick_nxt    = (div_cnt_r == DIV_TERM);                      // R1
        div_cnt_nxt = tick_nxt ? '0 : div_cnt_r + DIV_ONE;          // R1
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            div_cnt_r <= '0;                                        // R11
            tick_r    <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    // =================================================================
    // Counter
    // =================================================================
    udcl_pkg::udcl_op_t op;
    logic [3:0]         count_r;
    logic [3:0]         count_nxt;
    logic               dot_r;
    logic               dot_nxt;

    always_comb begin
        if (ctrl_in.clr) begin                                      // R12
            op = udcl_pkg::OP_CLEAR;
        end else if (ctrl_in.load) begin                            // R12
            op = udcl_pkg::OP_LOAD;
        end else if (tick_r && ctrl_in.en) begin                    // R2 R4
            op = ctrl_in.up ? udcl_pkg::OP_UP : udcl_pkg::OP_DOWN;  // R5
        end else begin
            op = udcl_pkg::OP_HOLD;
        end
    end

    always_comb begin
        unique case (op)
            udcl_pkg::OP_CLEAR: count_nxt = udcl_pkg::CNT_RESET;             // R6
            udcl_pkg::OP_LOAD:  count_nxt = ctrl_in.data;                    // R7 R8
            udcl_pkg::OP_UP:    count_nxt = count_r + udcl_pkg::CNT_STEP;    // R3 R12
            udcl_pkg::OP_DOWN:  count_nxt = count_r - udcl_pkg::CNT_STEP;    // R3 R12
            udcl_pkg::OP_HOLD:  count_nxt = count_r;                         // R4
            default:            count_nxt = count_r;
        endcase
        // Dot blinks with the seconds
        dot_nxt = tick_r ? ~dot_r : dot_r;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            count_r <= udcl_pkg::CNT_RESET;                         // R11
            dot_r   <= 1'b0;
        end else begin
            count_r <= count_nxt;
            dot_r   <= dot_nxt;
        end
    end

    // =================================================================
    // Registers
    // =================================================================
    logic [1:0]  ctrl_r;
    logic [1:0]  ctrl_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [3:0]  count_out_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (reg_wr && (reg_addr == udcl_pkg::REG_CTRL)) begin
            ctrl_nxt = reg_wdata[1:0];
        end
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                udcl_pkg::REG_CTRL: begin
                    rdata_nxt[1:0] = ctrl_r;
                end
                udcl_pkg::REG_STATUS: begin
                    rdata_nxt[udcl_pkg::STAT_CNT +: 4] = count_r;
                    rdata_nxt[udcl_pkg::STAT_EN]       = ctrl_in.en;
                    rdata_nxt[udcl_pkg::STAT_UP]       = ctrl_in.up;
                    rdata_nxt[udcl_pkg::STAT_CLR]      = ctrl_in.clr;
                    rdata_nxt[udcl_pkg::STAT_LOAD]     = ctrl_in.load;
                    rdata_nxt[udcl_pkg::STAT_DOT]      = dot_r;
                end
                udcl_pkg::REG_DIV: begin
                    rdata_nxt[DIV_W-1:0] = div_cnt_r;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_r      <= udcl_pkg::CTRL_RESET;
            rdata_r     <= '0;
            count_out_r <= udcl_pkg::CNT_RESET;
        end else begin
            ctrl_r      <= ctrl_nxt;
            rdata_r     <= rdata_nxt;
            count_out_r <= count_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign count_out = count_out_r;

    // =================================================================
    // Display
    // =================================================================
    udcl_seg_decode u_seg_decode (
        .core_clk (core_clk),
        .rstn     (rstn),
        .value    (count_r),                                        // R10
        .dot      (dot_r & ctrl_r[udcl_pkg::CTRL_DOT]),
        .invert   (ctrl_r[udcl_pkg::CTRL_INV]),
        .seg_r    (seg_out)
    );

    // =================================================================
    // Assertions
    // =================================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic plain_step;
    assign plain_step = tick_r && ctrl_in.en && !ctrl_in.clr && !ctrl_in.load;

    localparam logic [DIV_W:0] GAP_MAX = (DIV_W+1)'(TICK_CYCLES);
    localparam logic [DIV_W:0] GAP_ONE = (DIV_W+1)'(1);

    logic [DIV_W:0] gap_r;
    logic [DIV_W:0] gap_nxt;

    // Cycles since the last tick
    always_comb begin
        gap_nxt = tick_r ? '0 : gap_r + GAP_ONE;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            gap_r <= '0;
        end else begin
            gap_r <= gap_nxt;
        end
    end

    AST_TICK_AT_TERM: assert property ( // R1
        (div_cnt_r == DIV_TERM) |=> (tick_r && (div_cnt_r == '0))
    ) else $error("Divider terminal count gave no tick");

    AST_TICK_SPACING: assert property ( // R1
        tick_r |=> !tick_r
    ) else $error("Ticks came closer than the divider period");

    AST_NO_STEP_OFF_TICK: assert property ( // R2
        (!tick_r && !ctrl_in.clr && !ctrl_in.load) |=> $stable(count_r)
    ) else $error("Count moved without a tick");

    AST_HOLD_DISABLED: assert property ( // R4
        (!ctrl_in.en && !ctrl_in.clr && !ctrl_in.load) |=> $stable(count_r)
    ) else $error("Count moved while disabled");

    AST_COUNT_UP: assert property ( // R5
        (plain_step && ctrl_in.up) |=> (count_r == 4'($past(count_r) + 4'h1))
    ) else $error("Up step wrong");

    AST_COUNT_DOWN: assert property ( // R5
        (plain_step && !ctrl_in.up) |=> (count_r == 4'($past(count_r) - 4'h1))
    ) else $error("Down step wrong");

    AST_CLEAR_WINS: assert property ( // R6
        ctrl_in.clr |=> (count_r == 4'h0)
    ) else $error("Clear did not zero the count");

    AST_LOAD_DATA: assert property ( // R7
        (ctrl_in.load && !ctrl_in.clr) |=> (count_r == $past(ctrl_in.data))
    ) else $error("Load did not take the data inputs");

    AST_WRAP_UP: assert property ( // R12
        (plain_step && ctrl_in.up && (count_r == 4'hf)) |=> (count_r == 4'h0)
    ) else $error("Count did not wrap from F to 0");

    AST_SEG_DECODE: assert property ( // R10
        ##1 (seg_out.seg == (udcl_pkg::SEG_FONT[$past(count_r)]
                             ^ {7{$past(ctrl_r[udcl_pkg::CTRL_INV])}}))
    ) else $error("Segments do not show the count");

    property p_reset_zero;
        @(posedge core_clk) disable iff (1'b0)
        !rstn |=> ((count_r == 4'h0) && (div_cnt_r == '0) && (count_out == 4'h0));
    endproperty
    AST_RESET_ZERO: assert property (p_reset_zero) // R11
        else $error("Reset left count or divider nonzero");

    AST_WRAP_DOWN: assert property ( // R12
        (plain_step && !ctrl_in.up && (count_r == 4'h0)) |=> (count_r == 4'hf)
    ) else $error("Count did not wrap from 0 to F");

    AST_LOAD_OVER_STEP: assert property ( // R12
        (ctrl_in.load && !ctrl_in.clr && tick_r && ctrl_in.en)
            |=> (count_r == $past(ctrl_in.data))
    ) else $error("Counting beat a load");

    AST_STEP_SIZE: assert property ( // R2
        (!ctrl_in.clr && !ctrl_in.load)
            |=> ((count_r == $past(count_r))
                 || (count_r == 4'($past(count_r) + 4'h1))
                 || (count_r == 4'($past(count_r) - 4'h1)))
    ) else $error("Count moved by more than one step");

    AST_DIV_RANGE: assert property ( // R1
        div_cnt_r <= DIV_TERM
    ) else $error("Divider ran past its terminal count");

    AST_DIV_STEP: assert property ( // R1
        (div_cnt_r != DIV_TERM) |=> (div_cnt_r == DIV_W'($past(div_cnt_r) + DIV_ONE))
    ) else $error("Divider skipped a count");

    AST_NO_TICK_OFF_TERM: assert property ( // R1
        (div_cnt_r != DIV_TERM) |=> !tick_r
    ) else $error("Tick came away from the terminal count");

    AST_TICK_GAP: assert property ( // R1
        gap_r <= GAP_MAX
    ) else $error("Ticks came further apart than the divider period");

    AST_DOT_BLINK: assert property ( // R10
        1'b1 |=> (dot_r == ($past(dot_r) ^ $past(tick_r)))
    ) else $error("Blink bit did not follow the ticks");

    AST_DP_DRIVE: assert property ( // R10
        ##1 (seg_out.dp == ($past(dot_r & ctrl_r[udcl_pkg::CTRL_DOT])
                            ^ $past(ctrl_r[udcl_pkg::CTRL_INV])))
    ) else $error("Dot output does not follow blink and control");

    COV_LOAD: cover property (
        ctrl_in.load ##1 !ctrl_in.load ##[1:20] plain_step
    );
    COV_WRAP_UP: cover property (
        plain_step && ctrl_in.up && (count_r == 4'hf)
    );
    COV_WRAP_DOWN: cover property (
        plain_step && !ctrl_in.up && (count_r == 4'h0)
    );
    COV_CLEAR_OVER_LOAD: cover property (
        ctrl_in.clr && ctrl_in.load
    );
    COV_DOT_ON: cover property (
        tick_r && ctrl_r[udcl_pkg::CTRL_DOT]
    );

endmodule : udcl_counter
`default_nettype wire

// ==== tb/udcl_switch_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Switch bank in front of the counter
// =====================================================================
module udcl_switch_model (
    // Clock
    input  wire logic                core_clk,
    // Switch levels
    output var udcl_pkg::udcl_ctrl_t ctrl_in
);
    initial ctrl_in = '0;

    task automatic set_sw(input udcl_pkg::udcl_ctrl_t c);
        ctrl_in <= c;
    endtask : set_sw

    // Data and load up together for one edge, then load down
    task automatic preset(input logic [3:0] v);
        ctrl_in.data <= v;
        ctrl_in.load <= 1'b1;
        @(posedge core_clk);
        ctrl_in.load <= 1'b0;
    endtask : preset
endmodule : udcl_switch_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int unsigned TC = 4;
    localparam logic [6:0] FONT [16] = '{
        7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
        7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71
    };
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] mask;
        logic        timed;
    } udcl_note_t;

    logic                 core_clk;
    logic                 rstn;
    udcl_pkg::udcl_ctrl_t ctrl;
    logic [3:0]           reg_addr;
    logic [31:0]          reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [31:0]          reg_rdata;
    udcl_pkg::udcl_seg_t  seg;
    logic [3:0]           count_out;
    logic [3:0]           last_cnt = 4'h0;
    logic                 rd_d = 1'b0;
    int                   cyc = 0;
    int                   last_cyc = 0;
    int                   err_total = 0;
    int                   num_checks = 0;
    udcl_note_t           q_cnt [$];
    udcl_note_t           q_rd [$];
    udcl_note_t           n;

    udcl_counter #(.TICK_CYCLES(TC)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .ctrl_in(ctrl), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .seg_out(seg), .count_out(count_out)
    );
    udcl_switch_model i_sw (.core_clk(core_clk), .ctrl_in(ctrl));

    always #5 core_clk = ~core_clk;

    // =================================================================
    // Helpers
    // =================================================================
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic udcl_pkg::udcl_ctrl_t sw(input logic en, input logic up,
                                                input logic clr, input logic ld,
                                                input logic [3:0] d);
        return '{load: ld, up: up, clr: clr, en: en, data: d};
    endfunction : sw

    task automatic expect_cnt(input logic [3:0] v, input logic timed);
        q_cnt.push_back('{val: {28'h0, v}, mask: 32'hf, timed: timed});
    endtask : expect_cnt

    task automatic drain;
        for (int k = 0; k < 40 * TC && q_cnt.size() != 0; k++) @(posedge core_clk);
        if (q_cnt.size() != 0) begin
            err_total++;
            $display("[FAIL] count steps expected %0d more seen none", q_cnt.size());
            tally_and_finish();
        end
    endtask : drain

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        @(posedge core_clk);
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        q_rd.push_back('{val: exp, mask: m, timed: 1'b0});
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
    endtask : reg_read

    task automatic check_seg(input logic [3:0] v, input logic inv);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("seg", {25'h0, seg.seg}, {25'h0, inv ? ~FONT[v] : FONT[v]});
        chk("dot", {31'h0, seg.dp}, {31'h0, inv});
        @(posedge core_clk);
    endtask : check_seg

    // =================================================================
    // Monitor: every count change and read answer takes the oldest note
    // =================================================================
    always @(posedge core_clk) begin
        cyc  <= cyc + 1;
        rd_d <= reg_rd;
    end

    always @(negedge core_clk) begin
        if (rstn === 1'b1) begin
            if (rd_d === 1'b1) begin
                if (q_rd.size() != 0) n = q_rd.pop_front();
                else n = udcl_note_t'{32'hffff_ffff, 32'hffff_ffff, 1'b0};
                chk("reg_rdata", reg_rdata & n.mask, n.val);
            end
            if (count_out !== last_cnt) begin
                if (q_cnt.size() != 0) n = q_cnt.pop_front();
                else n = udcl_note_t'{32'hffff_ffff, 32'hffff_ffff, 1'b0};
                chk("count_out", {28'h0, count_out}, n.val);
                if (n.timed) chk("step spacing", 32'(cyc - last_cyc), 32'(TC));
                last_cnt = count_out;
                last_cyc = cyc;
            end
        end
    end

    // =================================================================
    // Main sequence
    // =================================================================
    initial begin
        logic [3:0] v;
        logic [3:0] cur;
        core_clk = 1'b0;
        rstn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cur = 4'h0;
        void'($urandom(48155));
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        chk("reset count", {28'h0, count_out}, 32'h0);
        chk("reset seg", {25'h0, seg.seg}, 32'h3f);
        @(posedge core_clk);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = cur ^ 4'(1 + $urandom % 15);
            expect_cnt(v, 1'b0);
            i_sw.preset(v);
            drain();
            check_seg(v, 1'b0);
            cur = v;
        end
        $display("test load done");
        i_sw.preset(4'he);
        if (cur != 4'he) expect_cnt(4'he, 1'b0);
        drain();
        expect_cnt(4'hf, 1'b0);
        expect_cnt(4'h0, 1'b1);
        expect_cnt(4'h1, 1'b1);
        i_sw.set_sw(sw(1'b1, 1'b1, 1'b0, 1'b0, 4'h0));
        drain();
        i_sw.set_sw(sw(1'b0, 1'b0, 1'b0, 1'b0, 4'h0));
        @(posedge core_clk);
        i_sw.preset(4'h0);
        expect_cnt(4'h0, 1'b0);
        drain();
        expect_cnt(4'hf, 1'b0);
        expect_cnt(4'he, 1'b1);
        expect_cnt(4'hd, 1'b1);
        i_sw.set_sw(sw(1'b1, 1'b0, 1'b0, 1'b0, 4'h0));
        drain();
        i_sw.set_sw(sw(1'b0, 1'b0, 1'b0, 1'b0, 4'h0));
        repeat (3 * TC) @(posedge core_clk);
        $display("test count done");
        expect_cnt(4'h0, 1'b0);
        i_sw.set_sw(sw(1'b1, 1'b1, 1'b1, 1'b1, 4'h7));
        repeat (2 * TC) @(posedge core_clk);
        expect_cnt(4'h7, 1'b0);
        i_sw.set_sw(sw(1'b1, 1'b1, 1'b0, 1'b1, 4'h7));
        repeat (2 * TC) @(posedge core_clk);
        expect_cnt(4'h8, 1'b0);
        expect_cnt(4'h9, 1'b1);
        i_sw.set_sw(sw(1'b1, 1'b1, 1'b0, 1'b0, 4'h7));
        drain();
        i_sw.set_sw(sw(1'b0, 1'b1, 1'b0, 1'b0, 4'h7));
        $display("test priority done");
        reg_write(4'h0, 32'h2);
        check_seg(4'h9, 1'b1);
        reg_read(4'h0, 32'h2, 32'hffff_ffff);
        reg_read(4'h4, 32'h29, 32'hffff_feff);
        reg_write(4'h4, 32'h0);
        reg_read(4'h4, 32'h29, 32'hffff_feff);
        reg_read(4'hc, 32'h0, 32'hffff_ffff);
        reg_read(4'h8, 32'h0, 32'hffff_fffc);
        reg_write(4'h0, 32'h1);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        v[0] = seg.dp;
        repeat (TC) @(negedge core_clk);
        chk("dot blink", {31'h0, seg.dp}, {31'h0, ~v[0]});
        @(posedge core_clk);
        reg_write(4'h0, 32'h0);
        check_seg(4'h9, 1'b0);
        $display("test registers done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
